// >>> plsup_top.sv
module plsup_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           ce,
    input  wire logic [plsup_pkg::AW-1:0]       paddr,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           cfg_done,
    input  wire logic                           cfg_eld_off,
    input  wire logic [plsup_pkg::NP-1:0]       cfg_fx,
    input  wire logic [plsup_pkg::NP-1:0]       link_led,
    input  wire logic [plsup_pkg::NP-1:0]       rx_er,
    input  wire logic [plsup_pkg::NP-1:0]       rx_dv,
    input  wire logic [4*plsup_pkg::NP-1:0]     rxd,
    input  wire logic [plsup_pkg::NP-1:0]       tx_clk,
    input  wire logic [4*plsup_pkg::NP-1:0]     txd_in,
    input  wire logic [plsup_pkg::NP-1:0]       tx_en_in,
    output logic      [4*plsup_pkg::NP-1:0]     txd,
    output logic      [plsup_pkg::NP-1:0]       tx_en,
    output logic      [plsup_pkg::NP-1:0]       tx_er,
    output wire logic [plsup_pkg::NP-1:0]       phy_rst_n,
    output wire logic [plsup_pkg::NP-1:0]       an_restart,
    output logic                                adv_100fd_only,
    output logic                                irq
);
    import plsup_pkg::*;

    function automatic plsup_mode_t port_mode(input logic [15:0] c,
                                              input int          p);
        return plsup_mode_t'(c[CTRL_MODE + 2*p +: 2]);
    endfunction

    logic [15:0]       ctrl_q;
    logic [CNT_W-1:0]  thr_q;
    logic [2*NP-1:0]   mask_q;
    logic [2*NP-1:0]   stat_q;
    logic [2*NP-1:0]   stat_d;
    logic [2*NP-1:0]   evt;
    logic              eld_en_q;
    logic [NP-1:0]     fx_q;
    logic              rst_mode;

    logic [SW-1:0]     syn;
    logic [4*NP-1:0]   rxd_s;
    logic [NP-1:0]     link_s;
    logic [NP-1:0]     rxer_s;
    logic [NP-1:0]     dv_s;
    logic [NP-1:0]     txc_s;

    logic [NP-1:0]     inb_q;
    logic [NP-1:0]     link_q;
    logic [NP-1:0]     link_d;
    logic [NP-1:0]     rxer_q;
    logic [NP-1:0]     rxevt;
    logic [NP-1:0]     txc_q;
    logic [1:0]        phase_q;
    logic [2*NP-1:0]   meas_q;
    logic [4:0]        dl_q [NP][DLY_N];
    logic [4:0]        dl_sel [NP];
    wire  [CNT_W*NP-1:0] err_cnt;
    wire  [NP-1:0]     fail_evt;

    logic              setup;
    logic              wr;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              hit_irq;
    logic              hit_mask;
    logic              hit_thr;
    logic              hit_err;
    logic              mapped;
    logic [31:0]       stat_word;
    logic [31:0]       rd_d;
    logic [2*NP-1:0]   w1c;

    // Pin inputs from outside the clock domain
    plsup_sync #(
        .W (SW)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({tx_clk, rx_dv, rx_er, link_led, rxd}),
        .q       (syn)
    );

    assign rxd_s  = syn[4*NP-1:0];
    assign link_s = syn[5*NP-1:4*NP];
    assign rxer_s = syn[6*NP-1:5*NP];
    assign dv_s   = syn[7*NP-1:6*NP];
    assign txc_s  = syn[8*NP-1:7*NP];

    // Optical port forces reset signalling on all ports
    assign rst_mode = |fx_q;
    assign rxevt    = rxer_s & ~rxer_q;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++)
        begin : g_port
            // Link from indication pin or in-band status
            assign link_d[gp] = (port_mode(ctrl_q, gp) == MODE_RGMII) ?
                                inb_q[gp] : link_s[gp];

            // Delay tap from manual setting or measured phase
            assign dl_sel[gp] = ctrl_q[CTRL_AUTO] ?
                                dl_q[gp][meas_q[2*gp +: 2]] :
                                dl_q[gp][ctrl_q[CTRL_DLY +: 2]];

            plsup_port u_port (
                .pclk       (pclk),
                .presetn    (presetn),
                .ce         (ce),
                .link_up    (link_q[gp]),
                .rx_er_evt  (rxevt[gp]),
                .eld_en     (eld_en_q),
                .rst_mode   (rst_mode),
                .thresh     (thr_q),
                .err_cnt    (err_cnt[CNT_W*gp +: CNT_W]),
                .an_restart (an_restart[gp]),
                .phy_rst_n  (phy_rst_n[gp]),
                .fail_evt   (fail_evt[gp])
            );
        end
    endgenerate

    // Link state, in-band capture, error edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inb_q  <= '0;
            link_q <= '0;
            rxer_q <= '0;
        end
        else if (ce)
        begin
            for (int p = 0; p < NP; p++)
            begin
                if (!dv_s[p])
                    inb_q[p] <= rxd_s[4*p];
            end
            link_q <= link_d;
            rxer_q <= rxer_s;
        end
    end

    // Transmit clock phase measurement
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q <= '0;
            txc_q   <= '0;
            meas_q  <= '0;
        end
        else if (ce)
        begin
            phase_q <= phase_q + 1'b1;
            txc_q   <= txc_s;
            for (int p = 0; p < NP; p++)
            begin
                if (txc_s[p] && !txc_q[p])
                    meas_q[2*p +: 2] <= phase_q;
            end
        end
    end

    // Transmit delay line and registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int p = 0; p < NP; p++)
            begin
                for (int i = 0; i < DLY_N; i++)
                    dl_q[p][i] <= '0;
            end
            txd   <= '0;
            tx_en <= '0;
            tx_er <= '0;
        end
        else if (ce)
        begin
            for (int p = 0; p < NP; p++)
            begin
                dl_q[p][0] <= {tx_en_in[p], txd_in[4*p +: 4]};
                for (int i = 1; i < DLY_N; i++)
                    dl_q[p][i] <= dl_q[p][i-1];
                tx_en[p] <= dl_sel[p][4];
                if (port_mode(ctrl_q, p) == MODE_RMII)
                    txd[4*p +: 4] <= {2'h0, dl_sel[p][1:0]};
                else
                    txd[4*p +: 4] <= dl_sel[p][3:0];
            end
            tx_er <= '0;
        end
    end

    // Detection enable, changed only by loaded configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eld_en_q <= 1'b1;
            fx_q     <= '0;
        end
        else if (ce && cfg_done)
        begin
            eld_en_q <= ~cfg_eld_off;
            fx_q     <= cfg_fx;
        end
    end

    // APB decode
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pready & pwrite;
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_stat = (paddr == ADDR_STAT);
    assign hit_irq  = (paddr == ADDR_IRQ);
    assign hit_mask = (paddr == ADDR_MASK);
    assign hit_thr  = (paddr == ADDR_THR);
    assign hit_err  = (paddr == ADDR_ERR);
    assign mapped   = hit_ctrl | hit_stat | hit_irq | hit_mask
                      | hit_thr | hit_err;

    assign stat_word = (32'(link_q) << STAT_LINK)
                     | (32'(eld_en_q) << STAT_ELD)
                     | (32'(rst_mode) << STAT_RMODE)
                     | (32'(meas_q) << STAT_MEAS);

    assign rd_d = hit_ctrl ? 32'(ctrl_q) :
                  hit_stat ? stat_word :
                  hit_irq  ? 32'(stat_q) :
                  hit_mask ? 32'(mask_q) :
                  hit_thr  ? 32'(thr_q) :
                  hit_err  ? 32'(err_cnt) : 32'h0000_0000;

    // Sticky events, set wins over write-one clear
    assign evt    = {fail_evt, link_q & ~link_d};
    assign w1c    = (wr && hit_irq) ? pwdata[2*NP-1:0] : '0;
    assign stat_d = (stat_q & ~w1c) | evt;

    // Bus answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_d : '0;
            pslverr <= setup && !mapped;
        end
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            thr_q  <= THR_RST;
            mask_q <= '0;
        end
        else if (ce && wr)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[15:0];
            if (hit_thr)
                thr_q <= pwdata[CNT_W-1:0];
            if (hit_mask)
                mask_q <= pwdata[2*NP-1:0];
        end
    end

    // Status, interrupt and advertisement outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q         <= '0;
            irq            <= 1'b0;
            adv_100fd_only <= 1'b0;
        end
        else if (ce)
        begin
            stat_q         <= stat_d;
            irq            <= |(stat_d & mask_q);
            adv_100fd_only <= ctrl_q[CTRL_ADVLIM];
        end
    end

    eld_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(eld_en_q) |-> $past(cfg_done) && $past(ce))
        else $error("detection disabled without configuration");

    txer_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ce) |-> tx_er == '0 ##1 tx_er == '0)
        else $error("transmit error driven");

    link_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && link_q[0] && !link_d[0] |=> stat_q[0] ##1 stat_q[0]
        || !ce)
        else $error("link loss not flagged");

endmodule

// >>> plsup_pkg.sv
package plsup_pkg;

    // Port count and field widths
    localparam int NP    = 2;
    localparam int AW    = 8;
    localparam int CNT_W = 8;
    localparam int SW    = 8 * NP;
    localparam int DLY_N = 4;

    // Register byte addresses
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_STAT = 8'h04;
    localparam logic [AW-1:0] ADDR_IRQ  = 8'h08;
    localparam logic [AW-1:0] ADDR_MASK = 8'h0C;
    localparam logic [AW-1:0] ADDR_THR  = 8'h10;
    localparam logic [AW-1:0] ADDR_ERR  = 8'h14;

    // Control field positions
    localparam int CTRL_AUTO   = 0;
    localparam int CTRL_ADVLIM = 1;
    localparam int CTRL_DLY    = 2;
    localparam int CTRL_MODE   = 8;

    // Status field positions
    localparam int STAT_LINK  = 0;
    localparam int STAT_ELD   = 4;
    localparam int STAT_RMODE = 5;
    localparam int STAT_MEAS  = 8;

    // Values after reset
    localparam logic [15:0]      CTRL_RST = 16'h0000;
    localparam logic [CNT_W-1:0] THR_RST  = 8'h10;

    // PHY reset pulse after a link failure
    localparam int CLK_NS     = 10;
    localparam int PHY_RST_US = 10;
    localparam int RST_CYC    = (PHY_RST_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int RST_CNT_W  = 11;

    typedef enum logic [1:0] {
        MODE_MII   = 2'h0,
        MODE_RMII  = 2'h1,
        MODE_RGMII = 2'h2
    } plsup_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RST  = 3'h4
    } plsup_state_t;

endpackage

// >>> plsup_sync.sv
module plsup_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Change accepted once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end
        else if (ce)
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
        end
    end

endmodule

// >>> plsup_port.sv
module plsup_port (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        link_up,
    input  wire logic                        rx_er_evt,
    input  wire logic                        eld_en,
    input  wire logic                        rst_mode,
    input  wire logic [plsup_pkg::CNT_W-1:0] thresh,
    output logic      [plsup_pkg::CNT_W-1:0] err_cnt,
    output logic                             an_restart,
    output logic                             phy_rst_n,
    output logic                             fail_evt
);
    import plsup_pkg::*;

    plsup_state_t         state_q;
    plsup_state_t         state_d;
    logic [RST_CNT_W-1:0] rcnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic                 trip;
    logic                 rst_done;

    // Error threshold reached on a live link
    assign trip = (state_q == ST_IDLE) && eld_en && link_up
                  && (err_cnt >= thresh);
    assign rst_done = (rcnt_q == RST_CNT_W'(RST_CYC - 1));

    // Count receive errors while idle on a live link
    assign cnt_d = (!link_up || state_q != ST_IDLE) ? '0 :
                   (rx_er_evt && err_cnt != '1) ? err_cnt + 1'b1 :
                   err_cnt;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (trip)
                    state_d = rst_mode ? ST_RST : ST_WAIT;
            ST_WAIT:
                if (!link_up)
                    state_d = ST_IDLE;
            ST_RST:
                if (rst_done)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= ST_IDLE;
            rcnt_q     <= '0;
            err_cnt    <= '0;
            an_restart <= 1'b0;
            phy_rst_n  <= 1'b0;
            fail_evt   <= 1'b0;
        end
        else if (ce)
        begin
            state_q    <= state_d;
            rcnt_q     <= (state_q == ST_RST) ? rcnt_q + 1'b1 : '0;
            err_cnt    <= cnt_d;
            an_restart <= trip && !rst_mode;
            phy_rst_n  <= (state_d != ST_RST);
            fail_evt   <= trip;
        end
    end

    restart_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        an_restart |-> state_q == ST_WAIT && !$past(rst_mode))
        else $error("restart issued outside copper mode");

    trip_react_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && trip |=> fail_evt && (an_restart || !phy_rst_n))
        else $error("threshold reached without reaction");

    wait_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state_q == ST_WAIT && link_up |=> state_q == ST_WAIT)
        else $error("left wait before link down");

    reset_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && trip && rst_mode |=> !phy_rst_n ##1 !phy_rst_n)
        else $error("failure did not pulse phy reset");

    rst_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(phy_rst_n) && $past(state_q) == ST_RST
        |-> $past(rcnt_q) == RST_CNT_W'(RST_CYC - 1))
        else $error("phy reset pulse length wrong");

endmodule

// >>> plsup_phy_model.sv
module plsup_phy_model #(
    parameter int RESP_DLY = 5,
    parameter int DOWN_CYC = 40,
    parameter int UP_CYC   = 20,
    parameter int PHASE_NS = 0
) (
    input  wire logic       pclk,
    input  wire logic       an_restart,
    input  wire logic       phy_rst_n,
    input  wire logic       want_link,
    input  wire logic       rgmii,
    output logic            link_led,
    output logic            rx_er,
    output logic            rx_dv,
    output logic      [3:0] rxd,
    output logic            tx_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    int   wait_q = 0;
    int   hold_q = 0;
    logic link_q = 1'b0;

    // Free-running transmit clock, 160 ns
    initial
    begin
        tx_clk = 1'b0;
        rx_er = 1'b0;
        rx_dv = 1'b0;
        #(PHASE_NS);
        forever #80 tx_clk = ~tx_clk;
    end

    // Reset drops link, release delayed
    always @(posedge pclk)
    begin
        if (phy_rst_n !== 1'b1)
        begin
            link_q <= 1'b0;
            hold_q <= UP_CYC;
            wait_q <= 0;
        end
        else if (an_restart === 1'b1)
            wait_q <= RESP_DLY;
        else if (wait_q > 0)
        begin
            wait_q <= wait_q - 1;
            if (wait_q == 1)
            begin
                link_q <= 1'b0;
                hold_q <= DOWN_CYC;
            end
        end
        else if (hold_q > 0)
            hold_q <= hold_q - 1;
        else
            link_q <= want_link;
    end

    assign link_led = link_q & ~rgmii;
    assign rxd      = rgmii ? {3'b101, link_q} : {~link_q, 3'b010};

    // Error bursts, each one a separate rising edge
    task automatic errors(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            rx_er <= 1'b1;
            rx_dv <= 1'b1;
            repeat (6) @(posedge pclk);
            rx_er <= 1'b0;
            rx_dv <= 1'b0;
            repeat (5) @(posedge pclk);
        end
    endtask
endmodule

// >>> test_plsup_top.sv
`define CHECK(nm, ex, gt) chk(nm, ex, gt)

module test_plsup_top;
    timeunit 1ns;
    timeprecision 100ps;
    import plsup_pkg::*;

    logic            pclk;
    logic            presetn;
    logic [AW-1:0]   paddr;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            cfg_done;
    logic            cfg_eld_off;
    logic [NP-1:0]   cfg_fx;
    logic [NP-1:0]   link_led;
    logic [NP-1:0]   rx_er;
    logic [NP-1:0]   rx_dv;
    logic [4*NP-1:0] rxd;
    logic [NP-1:0]   tx_clk;
    logic [4*NP-1:0] txd_in;
    logic [NP-1:0]   tx_en_in;
    logic [4*NP-1:0] txd;
    logic [NP-1:0]   tx_en;
    logic [NP-1:0]   tx_er;
    logic [NP-1:0]   phy_rst_n;
    logic [NP-1:0]   an_restart;
    logic            adv_100fd_only;
    logic            irq;
    logic [NP-1:0]   want_link;
    logic [NP-1:0]   rgmii;
    logic [31:0]     r;
    logic            e;
    logic            ce;
    logic [1:0]      ph;
    int              n_errors = 0;
    int              comparisons = 0;
    int              cycles = 0;
    int              an_cnt [NP] = '{default: 0};
    int              low_run [NP] = '{default: 0};
    int              low_len [NP] = '{default: 0};
    int              k;

    plsup_top plsup_top_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_done(cfg_done), .cfg_eld_off(cfg_eld_off), .cfg_fx(cfg_fx),
        .link_led(link_led), .rx_er(rx_er), .rx_dv(rx_dv), .rxd(rxd),
        .tx_clk(tx_clk), .txd_in(txd_in), .tx_en_in(tx_en_in), .txd(txd),
        .tx_en(tx_en), .tx_er(tx_er), .phy_rst_n(phy_rst_n),
        .an_restart(an_restart), .adv_100fd_only(adv_100fd_only), .irq(irq)
    );

    for (genvar g = 0; g < NP; g++)
    begin : g_phy
        plsup_phy_model #(
            .RESP_DLY (g == 0 ? 200 : 5),
            .PHASE_NS (g * 30)
        ) plsup_phy_model_inst (
            .pclk(pclk), .an_restart(an_restart[g]),
            .phy_rst_n(phy_rst_n[g]), .want_link(want_link[g]),
            .rgmii(rgmii[g]), .link_led(link_led[g]), .rx_er(rx_er[g]),
            .rx_dv(rx_dv[g]), .rxd(rxd[4*g +: 4]), .tx_clk(tx_clk[g])
        );
    end

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Restart pulses, reset pulse lengths, hang limit
    always @(posedge pclk)
    begin
        cycles++;
        for (int i = 0; i < NP; i++)
        begin
            if (an_restart[i] === 1'b1)
                an_cnt[i]++;
            if (phy_rst_n[i] !== 1'b1)
                low_run[i]++;
            else if (low_run[i] > 0)
            begin
                low_len[i] = low_run[i];
                low_run[i] = 0;
            end
        end
        if (cycles == 40000)
        begin
            n_errors++;
            $display("unexpected run_time: expected below %0d, seen %0d",
                     40000, cycles);
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, gt);
        comparisons++;
        if (gt !== ex)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, gt);
        end
    endtask

    task automatic apb(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        `CHECK("pready wait", 32'd1, n);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [AW-1:0] a,
                       input logic [31:0] m, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHECK(nm, ex, r & m);
    endtask

    task automatic cfg(input logic off, input logic [NP-1:0] fx);
        @(posedge pclk);
        cfg_done    <= 1'b1;
        cfg_eld_off <= off;
        cfg_fx      <= fx;
        @(posedge pclk);
        cfg_done    <= 1'b0;
    endtask

    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, cfg_done, cfg_eld_off} = 5'h00;
        {paddr, pwdata, cfg_fx, txd_in, tx_en_in} = '0;
        {want_link, rgmii} = '0;
        repeat (2) @(posedge pclk);
        `CHECK("phy_rst_n held", 2'h0, phy_rst_n);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHECK("phy_rst_n released", 2'h3, phy_rst_n);
        rdc("ctrl", ADDR_CTRL, 32'h0000FFFF, 32'(CTRL_RST));
        rdc("thr", ADDR_THR, 32'h000000FF, 32'(THR_RST));
        rdc("mask", ADDR_MASK, 32'h0000000F, 32'h0);
        rdc("eld enabled", ADDR_STAT, 32'h00000010, 32'h10);
        apb(1'b0, 8'h40, 32'h0);
        `CHECK("unmapped error", 1'b1, e);
        `CHECK("unmapped data", 32'h0, r);
        end_test("reset");
        low_len = '{default: 0};

        want_link <= 2'h3;
        repeat (40) @(posedge pclk);
        rdc("link state", ADDR_STAT, 32'h3, 32'h3);
        apb(1'b1, ADDR_THR, 32'h3);
        apb(1'b1, ADDR_MASK, 32'hF);
        g_phy[0].plsup_phy_model_inst.errors(2);
        repeat (10) @(posedge pclk);
        rdc("error count", ADDR_ERR, 32'hFFFF, 32'h0002);
        g_phy[0].plsup_phy_model_inst.errors(1);
        repeat (10) @(posedge pclk);
        `CHECK("restart count", 32'd1, an_cnt[0]);
        g_phy[0].plsup_phy_model_inst.errors(3);
        `CHECK("restart while waiting", 32'd1, an_cnt[0]);
        `CHECK("no copper reset", 32'd0, low_len[0]);
        `CHECK("other port restart", 32'd0, an_cnt[1]);
        repeat (250) @(posedge pclk);
        rdc("irq status", ADDR_IRQ, 32'hF, 32'h5);
        `CHECK("irq on", 1'b1, irq);
        apb(1'b1, ADDR_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        `CHECK("irq masked", 1'b0, irq);
        apb(1'b1, ADDR_MASK, 32'hF);
        apb(1'b1, ADDR_IRQ, 32'hF);
        repeat (2) @(posedge pclk);
        `CHECK("irq cleared", 1'b0, irq);
        rdc("count cleared", ADDR_ERR, 32'hFFFF, 32'h0);
        end_test("copper");

        cfg(1'b0, 2'h2);
        repeat (5) @(posedge pclk);
        rdc("reset mode", ADDR_STAT, 32'h30, 32'h30);
        g_phy[0].plsup_phy_model_inst.errors(3);
        repeat (20) @(posedge pclk);
        `CHECK("port reset", 1'b0, phy_rst_n[0]);
        `CHECK("other reset", 1'b1, phy_rst_n[1]);
        ce <= 1'b0;
        repeat (50) @(posedge pclk);
        ce <= 1'b1;
        repeat (1100) @(posedge pclk);
        `CHECK("reset length", 32'(RST_CYC + 50), low_len[0]);
        `CHECK("no restart", 32'd1, an_cnt[0]);
        apb(1'b1, ADDR_IRQ, 32'hF);
        end_test("optical");

        cfg(1'b1, 2'h0);
        repeat (5) @(posedge pclk);
        rdc("eld disabled", ADDR_STAT, 32'h30, 32'h0);
        g_phy[0].plsup_phy_model_inst.errors(3);
        repeat (20) @(posedge pclk);
        `CHECK("no trip restart", 32'd1, an_cnt[0]);
        `CHECK("no trip reset", 1'b1, phy_rst_n[0]);
        end_test("detection off");

        txd_in <= 8'hFF;
        apb(1'b0, ADDR_STAT, 32'h0);
        ph = r[9:8];
        `CHECK("phase offset", 2'h3, 2'(r[11:10] - r[9:8]));
        for (int t = 0; t < 5; t++)
        begin
            apb(1'b1, ADDR_CTRL,
                (t == 4) ? 32'h101 : (32'h100 | 32'(t << 2)));
            tx_en_in <= 2'h1;
            k = 0;
            do
            begin
                @(posedge pclk);
                if (k == 0)
                    tx_en_in <= 2'h0;
                k++;
            end
            while (tx_en[0] !== 1'b1 && k < 12);
            `CHECK("tx delay", 32'((t == 4 ? ph : t) + 3), k);
            `CHECK("rmii data", 8'hF3, txd);
            `CHECK("tx error low", 2'h0, tx_er);
        end
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        `CHECK("advert limit", 1'b1, adv_100fd_only);
        end_test("transmit");

        apb(1'b1, ADDR_CTRL, 32'h800);
        rgmii <= 2'h2;
        repeat (20) @(posedge pclk);
        rdc("inband up", ADDR_STAT, 32'h2, 32'h2);
        want_link <= 2'h1;
        repeat (20) @(posedge pclk);
        rdc("inband down", ADDR_STAT, 32'h2, 32'h0);
        end_test("rgmii");
        results();
    end
endmodule
